// ==== hw/hsp_top.sv ====
/*
  Reset sequencing, strap sampling, shared suspend LED pin and APB
  register slave of the hub strap and status pin block.
  Assumes pins are asynchronous to mclk_in and the hub core signals
  are on mclk_in.
*/
// Design decisions made here: the APB interface to the registers and the address map.
module hsp_top
  import hsp_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic reset_n_in,
  input wire logic supply_ok_in,
  input wire logic ref_clock_in,
  input wire logic [2:0] cfg_sel_in,
  input wire logic fixed_port_strap_hi_in,
  input wire logic suspend_led_in,
  input wire logic test_mode_in,
  input wire logic hub_configured_in,
  input wire logic hub_suspended_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic suspend_led_out,
  output logic suspend_led_oe_n_out,
  output logic crystal_out,
  output logic hub_reset_out,
  output logic [1:0] fixed_port_code_out,
  output logic self_powered_out,
  output logic strap_enabled_out,
  output logic [2:0] cfg_sel_out,
  output logic test_active_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  hsp_sync_if #(.W(SYNC_W)) pins_if ();

  assign pins_if.raw = {cfg_sel_in, supply_ok_in, test_mode_in,
                        reset_n_in, fixed_port_strap_hi_in,
                        suspend_led_in, ref_clock_in};

  hsp_sync #(.W(SYNC_W)) u_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .pins(pins_if.sync_side)
  );

  logic ref_s;
  logic shared_s;
  logic strap_hi_s;
  logic rstn_s;
  logic test_s;
  logic supply_s;
  logic [2:0] cfg_s;

  assign ref_s = pins_if.clean[SY_REF];
  assign shared_s = pins_if.clean[SY_SHARED];
  assign strap_hi_s = pins_if.clean[SY_STRAP_HI];
  assign rstn_s = pins_if.clean[SY_RESET_N];
  assign test_s = pins_if.clean[SY_TEST];
  assign supply_s = pins_if.clean[SY_SUPPLY];
  assign cfg_s = pins_if.clean[SY_CFG_LSB +: 3];

  // ----------------------------------------------------------------
  // Reference clock drive and activity monitor
  // ----------------------------------------------------------------
  logic ref_prev;
  logic ref_ok;
  logic [CNT_W-1:0] ref_idle_cnt;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      crystal_out <= 1'b0;
    end else begin
      crystal_out <= ~ref_clock_in; // R3
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ref_prev <= 1'b0;
      ref_ok <= 1'b0;
      ref_idle_cnt <= '0;
    end else begin
      ref_prev <= ref_s;
      if (ref_s != ref_prev) begin
        ref_idle_cnt <= '0;
        ref_ok <= 1'b1; // R3
      end else if (ref_idle_cnt == REF_WIN_CNT) begin
        ref_ok <= 1'b0; // R3
      end else begin
        ref_idle_cnt <= ref_idle_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  hsp_state_e state;
  hsp_state_e next_state;
  logic [CNT_W-1:0] por_cnt;
  logic [CNT_W-1:0] rst_low_cnt;

  always_comb begin
    next_state = state;
    case (state)
      ST_POR: begin
        if (supply_s && por_cnt == POR_LAST_CNT) begin // R2
          next_state = rstn_s ? ST_LATCH : ST_RESET;
        end
      end
      ST_RESET: begin
        if (!supply_s) begin
          next_state = ST_POR;
        end else if (rstn_s) begin
          next_state = ST_LATCH; // R9
        end
      end
      ST_LATCH: begin
        next_state = ST_RUN;
      end
      ST_RUN: begin
        if (!supply_s) begin
          next_state = ST_POR; // R2
        end else if (!rstn_s && rst_low_cnt == RST_LAST_CNT) begin
          next_state = ST_RESET; // R1
        end
      end
      default: begin
        next_state = ST_POR;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state <= ST_POR;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      por_cnt <= '0;
    end else if (state != ST_POR || !supply_s) begin
      por_cnt <= '0; // R2
    end else if (por_cnt != POR_LAST_CNT) begin
      por_cnt <= por_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rst_low_cnt <= '0;
    end else if (state != ST_RUN || rstn_s) begin
      rst_low_cnt <= '0; // R1
    end else if (rst_low_cnt != RST_LAST_CNT) begin
      rst_low_cnt <= rst_low_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      hub_reset_out <= 1'b1;
    end else begin
      hub_reset_out <= (state != ST_RUN); // R2
    end
  end

  // ----------------------------------------------------------------
  // Strap and configuration latch
  // ----------------------------------------------------------------
  logic [2:0] cfg_latch;
  logic [1:0] strap_code_latch;
  logic self_pwr_latch;
  logic strap_en_latch;
  logic strap_en_now;

  assign strap_en_now = (cfg_s == CFG_DEFAULT) || (cfg_s == CFG_BUS_PWR);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cfg_latch <= 3'h0;
      strap_code_latch <= 2'h0;
      self_pwr_latch <= 1'b0;
      strap_en_latch <= 1'b0;
    end else if (state == ST_LATCH) begin // R11
      cfg_latch <= cfg_s; // R9
      strap_en_latch <= strap_en_now; // R10
      strap_code_latch <= {strap_hi_s, shared_s}; // R6
      self_pwr_latch <= shared_s && (cfg_s != CFG_BUS_PWR); // R5
    end
  end

  // ----------------------------------------------------------------
  // APB register slave
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] status_word;
  logic [1:0] eff_code;
  logic eff_self_pwr;
  logic active_low;
  logic setup_ph;
  logic access_ph;
  logic addr_bad;

  assign eff_code = strap_en_latch ? strap_code_latch
                                   : ctrl[CTRL_CODE_LSB +: 2]; // R10
  assign eff_self_pwr = strap_en_latch ? self_pwr_latch
                                       : ctrl[CTRL_SELF_PWR_BIT]; // R10
  assign active_low = eff_code[0]; // R7

  always_comb begin
    status_word = '0;
    status_word[ST_CFG_LSB +: 3] = cfg_latch;
    status_word[ST_CODE_LSB +: 2] = eff_code;
    status_word[ST_STRAP_EN_BIT] = strap_en_latch;
    status_word[ST_SELF_PWR_BIT] = eff_self_pwr;
    status_word[ST_ACT_LOW_BIT] = active_low;
    status_word[ST_IN_RESET_BIT] = (state != ST_RUN);
    status_word[ST_TEST_BIT] = test_s;
    status_word[ST_REF_OK_BIT] = ref_ok;
    status_word[ST_STATE_LSB +: 2] = state;
  end

  assign setup_ph = psel_in && !penable_in;
  assign access_ph = psel_in && penable_in && pready_out;
  assign addr_bad = !((paddr_in == REG_CTRL) ||
                      (paddr_in == REG_STATUS && !pwrite_in));

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= setup_ph;
      pslverr_out <= setup_ph && addr_bad;
      if (setup_ph && !pwrite_in && paddr_in == REG_CTRL) begin
        prdata_out <= ctrl;
      end else if (setup_ph && !pwrite_in && paddr_in == REG_STATUS) begin
        prdata_out <= status_word;
      end else begin
        prdata_out <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ctrl <= CTRL_RESET;
    end else if (access_ph && pwrite_in && paddr_in == REG_CTRL) begin
      ctrl <= pwdata_in & CTRL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Shared suspend LED pin and status outputs
  // ----------------------------------------------------------------
  logic led_on;
  logic xnor_val;

  assign led_on = ctrl[CTRL_LED_EN_BIT] && hub_configured_in &&
                  !hub_suspended_in; // R4
  assign xnor_val = ~^{cfg_s, supply_s, rstn_s, strap_hi_s, shared_s};

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      suspend_led_out <= 1'b0;
      suspend_led_oe_n_out <= 1'b1;
    end else if (test_s) begin
      suspend_led_out <= xnor_val; // R8
      suspend_led_oe_n_out <= 1'b0;
    end else if (state == ST_RUN) begin
      suspend_led_out <= led_on ^ active_low; // R7
      suspend_led_oe_n_out <= 1'b0;
    end else begin
      suspend_led_out <= 1'b0;
      suspend_led_oe_n_out <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      fixed_port_code_out <= 2'h0;
      self_powered_out <= 1'b0;
      strap_enabled_out <= 1'b0;
      cfg_sel_out <= 3'h0;
      test_active_out <= 1'b0;
    end else begin
      fixed_port_code_out <= eff_code; // R6
      self_powered_out <= eff_self_pwr; // R5
      strap_enabled_out <= strap_en_latch;
      cfg_sel_out <= cfg_latch;
      test_active_out <= test_s; // R8
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_min_low: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == ST_RUN ##1 state == ST_RESET) |->
      $past(rst_low_cnt) == RST_LAST_CNT) // R1
    else $error("reset taken before minimum low time");

  a_reset_short_ign: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == ST_RUN && supply_s && rst_low_cnt != RST_LAST_CNT) |=>
      state == ST_RUN) // R1
    else $error("short reset pulse left run state");

  a_por_time_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == ST_POR ##1 state != ST_POR) |->
      $past(por_cnt) == POR_LAST_CNT && hub_reset_out) // R2
    else $error("power-on reset released early");

  a_ref_idle_lost: assert property (@(posedge mclk_in) disable iff (rst_in)
    (ref_idle_cnt == REF_WIN_CNT && ref_s == ref_prev) |=> !ref_ok) // R3
    else $error("reference loss not flagged");

  a_led_suspend_off: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    (state == ST_RUN && !test_s && (!hub_configured_in || hub_suspended_in))
      |=> !suspend_led_oe_n_out && suspend_led_out == $past(active_low))
    // R4
    else $error("suspend LED asserted while not active");

  a_self_pwr_latch: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == ST_LATCH && cfg_s == CFG_DEFAULT) |=>
      self_pwr_latch == $past(shared_s)) // R5
    else $error("local power level not latched");

  a_strap_sample: assert property (@(posedge mclk_in) disable iff (rst_in)
    state == ST_LATCH |=>
      strap_code_latch == $past({strap_hi_s, shared_s})) // R6
    else $error("fixed port strap not sampled");

  a_led_polarity: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == ST_RUN && !test_s && led_on) |=>
      suspend_led_out == !$past(eff_code[0])) // R7
    else $error("LED polarity does not follow strap code");

  a_test_drive: assert property (@(posedge mclk_in) disable iff (rst_in)
    test_s |=> !suspend_led_oe_n_out &&
      suspend_led_out == $past(xnor_val)) // R8
    else $error("test mode pin not driving XNOR");

  a_cfg_latch: assert property (@(posedge mclk_in) disable iff (rst_in)
    state == ST_LATCH |=> cfg_latch == $past(cfg_s)) // R9
    else $error("config select not latched");

  a_strap_ignored: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == ST_RUN && !strap_en_latch) |=>
      fixed_port_code_out == $past(ctrl[CTRL_CODE_LSB +: 2])) // R10
    else $error("strap used while disabled");

  a_strap_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == ST_RUN && $past(state) == ST_RUN) |->
      $stable(strap_code_latch) && $stable(cfg_latch) &&
      $stable(self_pwr_latch)) // R11
    else $error("latched straps changed outside reset");

endmodule // hsp_top

// ==== hw/hsp_pkg.sv ====
/*
  Constants, register map and encodings for the hub strap, reset and
  status pin block.
  Assumes a single 20 MHz clock and an APB master with 32-bit data.
*/
// Contract
// R1 - Outside reset must stay low at least 1 us; shorter pulses may not reset.
// R2 - With reset tied high, internal power-on reset holds logic until supply stable.
// R3 - Device runs from a 24 MHz reference, crystal or external clock.
// R4 - Suspend LED negated when unconfigured or suspended; asserted when configured active.
// R5 - Local-power sense low means bus powered only; high means local supply.
// R6 - Straps enabled: sample two fixed-port bits at reset release, codes 00 to 11.
// R7 - LED polarity from sampled code: 00/10 active high, 01/11 active low.
// R8 - Test input asserted gives XNOR continuity mode; otherwise normal operation.
// R9 - Configuration-select pins are latched at reset release and pick the method.
// R10 - Straps honoured only for enabling codes; otherwise settings come from registers.
// R11 - Sampled straps and polarity stay constant until next reset.

package hsp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 20_000_000;
  localparam int unsigned CLK_MHZ = CLK_FREQ_HZ / 1_000_000;
  localparam int unsigned REF_CLK_MHZ = 24;
  localparam int unsigned RST_MIN_NS = 1000;
  localparam int unsigned RST_MIN_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned POR_TIME_US = 50;
  localparam int unsigned POR_CYC = POR_TIME_US * CLK_MHZ;
  localparam int unsigned REF_WIN_CYC = 16;

  localparam int unsigned CNT_W = 11;
  localparam logic [CNT_W-1:0] RST_LAST_CNT = CNT_W'(RST_MIN_CYC - 1);
  localparam logic [CNT_W-1:0] POR_LAST_CNT = CNT_W'(POR_CYC - 1);
  localparam logic [CNT_W-1:0] REF_WIN_CNT = CNT_W'(REF_WIN_CYC);

  // ----------------------------------------------------------------
  // Synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int unsigned SY_REF = 0;
  localparam int unsigned SY_SHARED = 1;
  localparam int unsigned SY_STRAP_HI = 2;
  localparam int unsigned SY_RESET_N = 3;
  localparam int unsigned SY_TEST = 4;
  localparam int unsigned SY_SUPPLY = 5;
  localparam int unsigned SY_CFG_LSB = 6;
  localparam int unsigned SYNC_W = 9;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;

  localparam int unsigned CTRL_CODE_LSB = 0;
  localparam int unsigned CTRL_SELF_PWR_BIT = 2;
  localparam int unsigned CTRL_LED_EN_BIT = 3;
  localparam logic [31:0] CTRL_MASK = 32'h0000_000f;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0008;

  localparam int unsigned ST_CFG_LSB = 0;
  localparam int unsigned ST_CODE_LSB = 3;
  localparam int unsigned ST_STRAP_EN_BIT = 5;
  localparam int unsigned ST_SELF_PWR_BIT = 6;
  localparam int unsigned ST_ACT_LOW_BIT = 7;
  localparam int unsigned ST_IN_RESET_BIT = 8;
  localparam int unsigned ST_TEST_BIT = 9;
  localparam int unsigned ST_REF_OK_BIT = 10;
  localparam int unsigned ST_STATE_LSB = 11;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CFG_DEFAULT = 3'b000,
    CFG_SMBUS = 3'b001,
    CFG_BUS_PWR = 3'b010,
    CFG_EEPROM = 3'b011,
    CFG_DPS = 3'b100,
    CFG_DPS_LED = 3'b101,
    CFG_PLAIN = 3'b110,
    CFG_GANGED = 3'b111
  } hsp_cfg_e;

  typedef enum logic [1:0] {
    ST_POR = 2'b00,
    ST_RESET = 2'b01,
    ST_LATCH = 2'b10,
    ST_RUN = 2'b11
  } hsp_state_e;

endpackage : hsp_pkg

// ==== hw/hsp_sync_if.sv ====
/*
  Bundle of raw pin levels and their synchronised, filtered copies.
  Assumes the raw side is driven by the top and the clean side by the
  synchroniser.
*/
interface hsp_sync_if #(parameter int W = 1) ();
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync_side (input raw, output clean);
  modport user_side (output raw, input clean);
endinterface : hsp_sync_if

// ==== hw/hsp_sync.sv ====
/*
  Three-flop synchroniser per bit; a change is taken once the second
  and third flops agree.
  Assumes raw levels may change at any time relative to mclk_in.
*/
module hsp_sync
  import hsp_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  hsp_sync_if.sync_side pins
);

  // ----------------------------------------------------------------
  // Per-bit chain
  // ----------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1;
    logic s2;
    logic s3;
    logic q;
    always_ff @(posedge mclk_in) begin
      if (rst_in) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        q <= 1'b0;
      end else begin
        s1 <= pins.raw[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          q <= s2;
        end
      end
    end
    assign pins.clean[i] = q;
  end

endmodule // hsp_sync

// ==== tb/hsp_board_model.sv ====
/*
  Board side of the hub strap block: strap resistors on the shared
  pin and the fixed-port high pin, the 24 MHz reference, system reset.
  Assumes the bench sets the strap levels and calls hold_reset.
*/
module hsp_board_model (
  input wire logic mclk_in,
  input wire logic led_level_in,
  input wire logic led_oe_n_in,
  input wire logic strap_lo_in,
  input wire logic strap_hi_in,
  output logic pin_out,
  output logic strap_hi_pin_out,
  output logic reset_n_out,
  output logic ref_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------
  // Released pin falls back to the strap resistor level
  assign pin_out = led_oe_n_in ? strap_lo_in : led_level_in;
  assign strap_hi_pin_out = strap_hi_in;

  initial begin
    ref_clock_out = 1'h0;
    forever #20.833 ref_clock_out = ~ref_clock_out;
  end

  initial reset_n_out = 1'h1;

  // ------------------------------------------------------------
  // Reset pulse of a given length in clock cycles
  // ------------------------------------------------------------
  task automatic hold_reset(input int cyc);
    @(posedge mclk_in);
    reset_n_out <= 1'h0;
    repeat (cyc) @(posedge mclk_in);
    reset_n_out <= 1'h1;
  endtask
endmodule // hsp_board_model

// ==== tb/hub_strap_status_pins_tb.sv ====
/*
  Self-checking bench for hsp_top: strap sampling per config code,
  LED polarity, reset filtering, power-on wait, test mode and APB.
  Assumes hsp_board_model stands on the pin side.
*/
`define CHK(nm, ex, gt) \
  begin \
    samples_checked++; \
    if ((gt) !== (ex)) begin \
      n_errors++; \
      $display("unexpected %s exp %0h got %0h", nm, ex, gt); \
    end \
  end

module hub_strap_status_pins_tb
  import hsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [2:0] cfg;
    logic hi;
    logic lo;
    logic [2:0] ctrl;
    logic [1:0] code;
    logic en;
    logic [1:0] slf;
  } hsp_row_s;

  // cfg, strap hi, strap lo, CTRL, code, strap on, self (2 = skip)
  hsp_row_s rows [11] = '{
    '{3'h0, 1'h0, 1'h0, 3'h7, 2'h0, 1'h1, 2'h2},
    '{3'h0, 1'h0, 1'h1, 3'h6, 2'h1, 1'h1, 2'h2},
    '{3'h0, 1'h1, 1'h0, 3'h5, 2'h2, 1'h1, 2'h2},
    '{3'h0, 1'h1, 1'h1, 3'h4, 2'h3, 1'h1, 2'h2},
    '{3'h2, 1'h1, 1'h1, 3'h4, 2'h3, 1'h1, 2'h0},
    '{3'h1, 1'h1, 1'h0, 3'h5, 2'h1, 1'h0, 2'h1},
    '{3'h3, 1'h0, 1'h1, 3'h2, 2'h2, 1'h0, 2'h0},
    '{3'h4, 1'h0, 1'h0, 3'h7, 2'h3, 1'h0, 2'h1},
    '{3'h5, 1'h1, 1'h1, 3'h0, 2'h0, 1'h0, 2'h0},
    '{3'h6, 1'h0, 1'h0, 3'h6, 2'h2, 1'h0, 2'h1},
    '{3'h7, 1'h1, 1'h0, 3'h1, 2'h1, 1'h0, 2'h0}
  };

  logic mclk_in;
  logic rst_in;
  logic supply_ok;
  logic test_mode;
  logic conf;
  logic susp;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [2:0] cfg_sel;
  logic strap_lo;
  logic strap_hi;
  logic pin_lvl;
  logic hi_pin;
  logic reset_n;
  logic ref_clk;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic led;
  logic led_oe_n;
  logic xtal;
  logic hub_rst;
  logic [1:0] code;
  logic self_pwr;
  logic strap_en;
  logic [2:0] cfg_out;
  logic test_act;
  logic [31:0] rd;
  logic er;
  int n_errors = 0;
  int samples_checked = 0;

  hsp_top DUT (
    .mclk_in(mclk_in), .rst_in(rst_in), .reset_n_in(reset_n),
    .supply_ok_in(supply_ok), .ref_clock_in(ref_clk),
    .cfg_sel_in(cfg_sel), .fixed_port_strap_hi_in(hi_pin),
    .suspend_led_in(pin_lvl), .test_mode_in(test_mode),
    .hub_configured_in(conf), .hub_suspended_in(susp),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .suspend_led_out(led), .suspend_led_oe_n_out(led_oe_n),
    .crystal_out(xtal), .hub_reset_out(hub_rst),
    .fixed_port_code_out(code), .self_powered_out(self_pwr),
    .strap_enabled_out(strap_en), .cfg_sel_out(cfg_out),
    .test_active_out(test_act)
  );

  hsp_board_model board (
    .mclk_in(mclk_in), .led_level_in(led), .led_oe_n_in(led_oe_n),
    .strap_lo_in(strap_lo), .strap_hi_in(strap_hi), .pin_out(pin_lvl),
    .strap_hi_pin_out(hi_pin), .reset_n_out(reset_n),
    .ref_clock_out(ref_clk)
  );

  // ------------------------------------------------------------
  // Clock, watchdog, closing
  // ------------------------------------------------------------
  initial begin
    mclk_in = 1'h0;
    forever #25 mclk_in = ~mclk_in;
  end

  initial begin
    repeat (20000) @(posedge mclk_in);
    n_errors++;
    wrap_up();
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Bus and wait helpers
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk_in);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'h1;
    // Look mid-cycle so the answer is read before its own edge
    do begin
      @(negedge mclk_in);
      k++;
    end while (pready !== 1'h1 && k < 20);
    rd = prdata;
    er = pslverr;
    @(posedge mclk_in);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wait_run();
    int k;
    k = 0;
    while (hub_rst !== 1'h0 && k < 200) begin
      @(posedge mclk_in);
      k++;
    end
    `CHK("hub_reset_out", 1'h0, hub_rst);
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    rst_in = 1'h1;
    supply_ok = 1'h0;
    test_mode = 1'h0;
    conf = 1'h0;
    susp = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    cfg_sel = 3'h0;
    strap_lo = 1'h0;
    strap_hi = 1'h0;
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'h0;
    apb(1'h0, REG_CTRL, 32'h0000_0000);
    `CHK("ctrl_reset", 32'h0000_0008, rd);
    apb(1'h0, 8'h08, 32'h0000_0000);
    `CHK("unmapped_err", 1'h1, er);
    `CHK("unmapped_data", 32'h0000_0000, rd);
    apb(1'h1, REG_STATUS, 32'hffff_ffff);
    `CHK("status_write_err", 1'h1, er);
    repeat (50) @(posedge mclk_in);
    `CHK("hub_reset_out", 1'h1, hub_rst);
    supply_ok <= 1'h1;
    repeat (990) @(posedge mclk_in);
    `CHK("hub_reset_out", 1'h1, hub_rst);
    wait_run();
    foreach (rows[i]) begin
      cfg_sel <= rows[i].cfg;
      strap_hi <= rows[i].hi;
      strap_lo <= rows[i].lo;
      conf <= 1'h0;
      susp <= 1'h0;
      board.hold_reset(30);
      `CHK("hub_reset_out", 1'h1, hub_rst);
      wait_run();
      apb(1'h1, REG_CTRL, {28'h0000_000, 1'h1, rows[i].ctrl});
      strap_hi <= ~rows[i].hi;
      strap_lo <= ~rows[i].lo;
      cfg_sel <= ~rows[i].cfg;
      repeat (10) @(posedge mclk_in);
      `CHK("fixed_port_code_out", rows[i].code, code);
      `CHK("strap_enabled_out", rows[i].en, strap_en);
      `CHK("cfg_sel_out", rows[i].cfg, cfg_out);
      if (rows[i].slf !== 2'h2) `CHK("self", rows[i].slf[0], self_pwr);
      `CHK("led_oe_n", 1'h0, led_oe_n);
      `CHK("led_unconf", rows[i].code[0], led);
      conf <= 1'h1;
      repeat (4) @(posedge mclk_in);
      `CHK("led_active", ~rows[i].code[0], led);
      susp <= 1'h1;
      repeat (4) @(posedge mclk_in);
      `CHK("led_susp", rows[i].code[0], led);
      `CHK("code_held", rows[i].code, code);
      apb(1'h0, REG_STATUS, 32'h0000_0000);
      `CHK("status_hi", {5'h1c, rows[i].code[0]}, {rd[12:8], rd[7]});
      `CHK("status_lo", {rows[i].en, rows[i].code, rows[i].cfg}, rd[5:0]);
    end
    board.hold_reset(8);
    repeat (25) begin
      @(posedge mclk_in);
      `CHK("hub_reset_out", 1'h0, hub_rst);
    end
    test_mode <= 1'h1;
    repeat (8) @(posedge mclk_in);
    `CHK("test_active_out", 1'h1, test_act);
    `CHK("led_oe_n", 1'h0, led_oe_n);
    test_mode <= 1'h0;
    repeat (8) @(posedge mclk_in);
    `CHK("test_active_out", 1'h0, test_act);
    wrap_up();
  end
endmodule // hub_strap_status_pins_tb
